// ---- pkg/adc_mode_pkg.sv ----
// Register map, field layout and reset values of the ADC input-mode block
`default_nettype none
package adc_mode_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_INPUT_MODE_LOW = 12'h000;
  localparam logic [11:0] OFF_INPUT_MODE_HIGH = 12'h004;
  localparam logic [11:0] OFF_CMP0_ENABLE = 12'h008;
  localparam logic [11:0] OFF_CMP1_ENABLE = 12'h00C;
  // Writable masks; everything else reads zero
  localparam logic [15:0] MODE_LOW_MASK = 16'h555F;
  localparam logic [15:0] MODE_HIGH_MASK = 16'h1555;
  localparam logic [15:0] CMP_EN_MASK = 16'h4FFF;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int unsigned NUM_CHANNELS = 15;
  localparam int unsigned NUM_PAIRED = 2;
  localparam int unsigned PAIR_BIT0 = 1;
  localparam int unsigned PAIR_BIT1 = 3;
  localparam int unsigned CMP_CH14_BIT = 14;

  typedef struct packed {
    logic [14:0] signed_result;
    logic [1:0] pair_mode;
  } channel_cfg_s;

  typedef struct packed {
    logic [14:0] cmp1_select;
    logic [14:0] cmp0_select;
  } compare_cfg_s;
endpackage
`default_nettype wire

// ---- logic/adc_input_mode_regs.sv ----
// APB register block for ADC channel input mode, data format and comparator select
// Operation
// RULE1 - Bits 3 and 1 of the low input-mode register make channels 1 and 0 pseudo-differential when set.
// RULE2 - Even bits of the low input-mode register make channels 0 to 7 produce signed data when set.
// RULE3 - Odd bits 15 down to 5 of the low input-mode register are unimplemented and read zero.
// RULE4 - Even bits of the high register set signed data for channels 8 to 14; odd bits and 15 to 13 read zero.
// RULE5 - There are two comparator channel-enable registers, one per comparator, with identical layout.
// RULE6 - Bit 14 of a comparator enable register routes channel 14's result to that comparator.
// RULE7 - Bits 11 to 0 of a comparator enable register route channels 0 to 11 to that comparator.
// RULE8 - Bits 15, 13 and 12 of a comparator enable register are unimplemented and read zero.
// RULE9 - All implemented bits clear to zero at reset.
`default_nettype none
module adc_input_mode_regs
  import adc_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_mode_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output adc_mode_pkg::channel_cfg_s channel_cfg,
  output adc_mode_pkg::compare_cfg_s compare_cfg
);
  import adc_mode_pkg::*;

  logic [15:0] mode_low_q, mode_low_d;
  logic [15:0] mode_high_q, mode_high_d;
  logic [15:0] cmp0_q, cmp0_d;
  logic [15:0] cmp1_q, cmp1_d;
  logic [31:0] prdata_q, prdata_d;

  // Byte lanes only reach the low half; the upper 16 data bits are ignored
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0])
      v[7:0] = wd[7:0];
    if (strb[1])
      v[15:8] = wd[15:8];
    return v & mask;
  endfunction

  // Comparator channel select keeps the unimplemented 13:12 gap as zeros and drops bit 15
  function automatic logic [14:0] cmp_select(input logic [15:0] r);
    return {r[CMP_CH14_BIT], 2'b00, r[11:0]};
  endfunction

  // Full address compare, so no register answers at an alias
  wire access = psel && penable;
  wire wr_en = access && pwrite;
  wire hit_low = paddr == OFF_INPUT_MODE_LOW;
  wire hit_high = paddr == OFF_INPUT_MODE_HIGH;
  wire hit_cmp0 = paddr == OFF_CMP0_ENABLE;
  wire hit_cmp1 = paddr == OFF_CMP1_ENABLE;
  wire hit_any = hit_low || hit_high || hit_cmp0 || hit_cmp1;

  assign mode_low_d = (wr_en && hit_low) ? merge(mode_low_q, pwdata, pstrb, MODE_LOW_MASK) : mode_low_q; // RULE1 RULE2 RULE3
  assign mode_high_d = (wr_en && hit_high) ? merge(mode_high_q, pwdata, pstrb, MODE_HIGH_MASK) : mode_high_q; // RULE4
  assign cmp0_d = (wr_en && hit_cmp0) ? merge(cmp0_q, pwdata, pstrb, CMP_EN_MASK) : cmp0_q; // RULE5 RULE8
  assign cmp1_d = (wr_en && hit_cmp1) ? merge(cmp1_q, pwdata, pstrb, CMP_EN_MASK) : cmp1_q; // RULE5 RULE8

  wire [15:0] rd_sel = hit_low ? mode_low_q : hit_high ? mode_high_q : hit_cmp0 ? cmp0_q : hit_cmp1 ? cmp1_q : 16'h0000;
  assign prdata_d = (psel && !penable && !pwrite) ? {16'h0000, rd_sel} : prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_low_q <= REG_RESET; // RULE9
      mode_high_q <= REG_RESET; // RULE9
      cmp0_q <= REG_RESET; // RULE9
      cmp1_q <= REG_RESET; // RULE9
      prdata_q <= {16'h0000, REG_RESET};
    end
    else
    begin
      mode_low_q <= mode_low_d;
      mode_high_q <= mode_high_d;
      cmp0_q <= cmp0_d;
      cmp1_q <= cmp1_d;
      prdata_q <= prdata_d;
    end
  end

  // One wait-free access phase; read data captured in setup
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata = prdata_q;

  // Signed flags: channels 0-7 at low even bits, 8-14 at high even bits
  function automatic logic [14:0] sign_flags(input logic [15:0] lo, input logic [15:0] hi);
    logic [14:0] f;
    f = 15'h0000;
    for (int i = 0; i < 8; i++)
      f[i] = lo[2*i];
    for (int i = 0; i < 7; i++)
      f[8+i] = hi[2*i];
    return f;
  endfunction

  // Whole structs in one assignment each, so every output bit has one driver
  wire [14:0] sign_bits = sign_flags(mode_low_q, mode_high_q); // RULE2 RULE4
  wire [1:0] pair_bits = {mode_low_q[PAIR_BIT1], mode_low_q[PAIR_BIT0]}; // RULE1
  assign channel_cfg = '{signed_result: sign_bits, pair_mode: pair_bits};
  assign compare_cfg = '{cmp1_select: cmp_select(cmp1_q), cmp0_select: cmp_select(cmp0_q)}; // RULE5 RULE6 RULE7

  property p_low_reserved;
    @(posedge pclk) disable iff (!presetn) (mode_low_q & ~MODE_LOW_MASK) == 16'h0000;
  endproperty
  a_low_reserved: assert property (p_low_reserved) else $error("low mode reserved bit set"); // RULE3

  property p_high_reserved;
    @(posedge pclk) disable iff (!presetn) (mode_high_q & ~MODE_HIGH_MASK) == 16'h0000;
  endproperty
  a_high_reserved: assert property (p_high_reserved) else $error("high mode reserved bit set"); // RULE4

  property p_cmp_reserved;
    @(posedge pclk) disable iff (!presetn) ((cmp0_q | cmp1_q) & ~CMP_EN_MASK) == 16'h0000;
  endproperty
  a_cmp_reserved: assert property (p_cmp_reserved) else $error("comparator reserved bit set"); // RULE8

  property p_pair_write;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_low && pstrb[0])
      |=> channel_cfg.pair_mode == {$past(pwdata[3]), $past(pwdata[1])};
  endproperty
  a_pair_write: assert property (p_pair_write) else $error("pair mode not taken from write"); // RULE1

  property p_sign_low_write;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_low && pstrb[1])
      |=> channel_cfg.signed_result[7] == $past(pwdata[14]);
  endproperty
  a_sign_low_write: assert property (p_sign_low_write) else $error("channel 7 sign wrong"); // RULE2

  property p_sign_high_write;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_high && pstrb[1])
      |=> channel_cfg.signed_result[14] == $past(pwdata[12]);
  endproperty
  a_sign_high_write: assert property (p_sign_high_write) else $error("channel 14 sign wrong"); // RULE4

  property p_cmp14;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_cmp1 && pstrb[1])
      |=> compare_cfg.cmp1_select[14] == $past(pwdata[14]) && compare_cfg.cmp0_select == $past(compare_cfg.cmp0_select);
  endproperty
  a_cmp14: assert property (p_cmp14) else $error("comparator 1 channel 14 wrong"); // RULE5 RULE6

  property p_cmp_low;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_cmp0 && pstrb[0])
      |=> compare_cfg.cmp0_select[7:0] == $past(pwdata[7:0]);
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("comparator 0 low channels wrong"); // RULE7

  // Hold checks mixed with write and read checks; a stray write enable would show up in a hold check first
  property p_pair_hold;
    @(posedge pclk) disable iff (!presetn) !(wr_en && hit_low && pstrb[0])
      |=> $stable(channel_cfg.pair_mode);
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("pair mode changed without write"); // RULE1

  property p_sign_low_bits;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_low && pstrb[0])
      |=> channel_cfg.signed_result[3:0] == {$past(pwdata[6]), $past(pwdata[4]), $past(pwdata[2]), $past(pwdata[0])};
  endproperty
  a_sign_low_bits: assert property (p_sign_low_bits) else $error("channels 3 to 0 sign wrong"); // RULE2

  property p_sign_high_bits;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_high && pstrb[0])
      |=> channel_cfg.signed_result[11:8] == {$past(pwdata[6]), $past(pwdata[4]), $past(pwdata[2]), $past(pwdata[0])};
  endproperty
  a_sign_high_bits: assert property (p_sign_high_bits) else $error("channels 11 to 8 sign wrong"); // RULE4

  property p_sign_hold;
    @(posedge pclk) disable iff (!presetn) !(wr_en && (hit_low || hit_high))
      |=> $stable(channel_cfg.signed_result);
  endproperty
  a_sign_hold: assert property (p_sign_hold) else $error("sign flags changed without write"); // RULE2 RULE4

  property p_cmp0_mid;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_cmp0 && pstrb[1])
      |=> compare_cfg.cmp0_select[13:8] == {2'b00, $past(pwdata[11:8])};
  endproperty
  a_cmp0_mid: assert property (p_cmp0_mid) else $error("comparator 0 channels 13 to 8 wrong"); // RULE7 RULE8

  property p_cmp1_low;
    @(posedge pclk) disable iff (!presetn) (wr_en && hit_cmp1 && pstrb[0])
      |=> compare_cfg.cmp1_select[7:0] == $past(pwdata[7:0]);
  endproperty
  a_cmp1_low: assert property (p_cmp1_low) else $error("comparator 1 low channels wrong"); // RULE5 RULE7

  property p_cmp_hold;
    @(posedge pclk) disable iff (!presetn) !(wr_en && hit_cmp0)
      |=> $stable(compare_cfg.cmp0_select);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("comparator 0 select changed without write"); // RULE5

  property p_read_reserved_low;
    @(posedge pclk) disable iff (!presetn) (psel && !penable && !pwrite && hit_low)
      |=> (prdata & ~{16'h0000, MODE_LOW_MASK}) == 32'h0000_0000;
  endproperty
  a_read_reserved_low: assert property (p_read_reserved_low) else $error("low mode reserved bit read as one"); // RULE3

  property p_read_reserved_cmp;
    @(posedge pclk) disable iff (!presetn) (psel && !penable && !pwrite && (hit_cmp0 || hit_cmp1))
      |=> (prdata & ~{16'h0000, CMP_EN_MASK}) == 32'h0000_0000;
  endproperty
  a_read_reserved_cmp: assert property (p_read_reserved_cmp) else $error("comparator reserved bit read as one"); // RULE8

  property p_reset_read;
    @(posedge pclk) $rose(presetn) |-> prdata == 32'h0000_0000;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("read data not clear after reset"); // RULE9

  property p_reset_clear;
    @(posedge pclk) $rose(presetn) |-> channel_cfg == '0 && compare_cfg == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("config not clear after reset"); // RULE9

  c_write_low: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_low);
  c_write_cmp1: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_cmp1);
  c_read_high: cover property (@(posedge pclk) disable iff (!presetn) access && !pwrite && hit_high);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_partial_strobe: cover property (@(posedge pclk) disable iff (!presetn) wr_en && pstrb[1:0] == 2'b01);
endmodule
`default_nettype wire

// ---- testbench/test_adc_input_mode_regs.sv ----
// Self-checking bench for the ADC input-mode register block
`default_nettype none
module test_adc_input_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_mode_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, wd, lf = 32'h0001_17d0;
  logic [3:0] pstrb = 4'h0, st;
  logic [1:0] k;
  channel_cfg_s channel_cfg;
  compare_cfg_s compare_cfg;
  logic [15:0] mdl [4];
  logic [11:0] offs [4] = '{OFF_INPUT_MODE_LOW, OFF_INPUT_MODE_HIGH, OFF_CMP0_ENABLE, OFF_CMP1_ENABLE};
  logic [15:0] msk [4] = '{MODE_LOW_MASK, MODE_HIGH_MASK, CMP_EN_MASK, CMP_EN_MASK};
  int n_fail = 0, num_checks = 0;
  adc_input_mode_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_cfg(channel_cfg), .compare_cfg(compare_cfg));
  initial forever #5 pclk = ~pclk;
  function logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected register after a write: lanes 0 and 1 only, unimplemented bits zero
  function logic [15:0] reg_after(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s,
                                  input logic [15:0] m);
    reg_after = old;
    if (s[0])
      reg_after[7:0] = d[7:0];
    if (s[1])
      reg_after[15:8] = d[15:8];
    reg_after = reg_after & m;
  endfunction
  function channel_cfg_s exp_channel(input logic [15:0] lo, input logic [15:0] hi);
    for (int i = 0; i < 8; i++)
      exp_channel.signed_result[i] = lo[2*i];
    for (int i = 8; i < 15; i++)
      exp_channel.signed_result[i] = hi[2*(i-8)];
    exp_channel.pair_mode = {lo[3], lo[1]};
  endfunction
  task close_out();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      mdl[i] = 16'h0000;
  endtask
  task chk_all();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, offs[i], 32'h0000_0000, 4'h0);
      chk("read", rd, {16'h0000, mdl[i]});
    end
    chk("channel_cfg", {15'h0000, channel_cfg}, {15'h0000, exp_channel(mdl[0], mdl[1])});
    chk("compare_cfg", {2'h0, compare_cfg}, {2'h0, mdl[3][14:0], mdl[2][14:0]});
  endtask
  initial
  begin
    do_reset();
    chk_all();
    // First four writes set every bit, so reserved bits are probed early
    for (int n = 0; n < 60; n++)
    begin
      lf = nxt(lf);
      k = (n < 4) ? n[1:0] : lf[1:0];
      st = (n < 4) ? 4'hf : lf[5:2];
      lf = nxt(lf);
      wd = (n < 4) ? 32'hffff_ffff : lf;
      apb(1'b1, offs[k], wd, st);
      chk("pslverr", {31'h0000_0000, err}, 32'h0000_0000);
      mdl[k] = reg_after(mdl[k], wd, st, msk[k]);
      chk_all();
    end
    apb(1'b1, 12'h010, 32'hffff_ffff, 4'hf);
    chk("pslverr", {31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000, 4'h0);
    chk("unmapped", rd, 32'h0000_0000);
    chk("pslverr", {31'h0000_0000, err}, 32'h0000_0001);
    chk_all();
    // Upper lanes only: nothing may change
    apb(1'b1, OFF_CMP0_ENABLE, 32'hffff_ffff, 4'hc);
    chk("pslverr", {31'h0000_0000, err}, 32'h0000_0000);
    mdl[2] = reg_after(mdl[2], 32'hffff_ffff, 4'hc, msk[2]);
    chk_all();
    do_reset();
    chk_all();
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
